//--- rtl/ewc_config_regs.sv
/*
  Expanded-bank configuration registers: port drive, two stop-recovery controls
  and watchdog mode, reached over Avalon-MM with waitrequest.
  Assumes one clock, synchronous active-high reset for power-on, and a one-cycle
  stop-recovery pulse from the wake-up logic.
*/
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/100ps

module ewc_config_regs (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 stopRecovery,
  input  wire logic [5:0]           avsAddress,
  input  wire logic                 avsRead,
  input  wire logic                 avsWrite,
  input  wire logic [31:0]          avsWriteData,
  input  wire logic [3:0]           avsByteEnable,
  output logic      [31:0]          avsReadData,
  output logic                      avsWaitRequest,
  output ewc_pkg::ewc_drive_t       driveSel,
  output ewc_pkg::ewc_wdt_cfg_t     wdtCfg,
  output logic      [6:0]           recoveryCtrl,
  output logic      [1:0]           recoverySrc2
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  pdc_r, pdc_nxt;                 // Port drive configuration
  logic [7:0]  sr1_r, sr1_nxt;                 // Recovery control one, flag in bit 7
  logic [7:0]  sr2_r, sr2_nxt;                 // Recovery control two
  logic [7:0]  wdm_r, wdm_nxt;                 // Watchdog mode
  logic [31:0] rdData_r, rdData_nxt;           // Registered read data
  logic        ack_r, ack_nxt;                 // Wait state done, access completes
  logic        wrHit;                          // Write completing this cycle
  logic        regAligned;                     // Word-aligned byte address
  logic        newRequest;                     // Request not yet acknowledged
  logic        pdcWrite;                       // Write strobe, port drive
  logic        sr1Write;                       // Write strobe, recovery one
  logic        sr2Write;                       // Write strobe, recovery two
  logic        wdmWrite;                       // Write strobe, watchdog mode
  logic [3:0]  regIdx;                         // Register index from address

  // Timeout lookup by tap code
  function automatic logic [11:0] tap_clks(input logic [1:0] tap);
    unique case (tap)
      2'b00: tap_clks = ewc_pkg::TAP0_CLKS;
      2'b01: tap_clks = ewc_pkg::TAP1_CLKS;
      2'b10: tap_clks = ewc_pkg::TAP2_CLKS;
      2'b11: tap_clks = ewc_pkg::TAP3_CLKS;
    endcase
  endfunction

  // Write strobe for one register index, only when the access completes
  function automatic logic write_to(input logic [3:0] idx, input logic [3:0] target, input logic hit);
    write_to = hit && (idx == target);
  endfunction

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The address port carries a four-bit index above a two-bit byte offset
  if (ewc_pkg::ADDR_W != $bits(avsAddress)) begin : g_addr_w_check
    $error("register address width does not match the address port");
  end
  // The flag and the oscillator drive field must sit inside the register word
  if (ewc_pkg::BIT_RECOVER_FLAG >= $bits(sr1_r) || ewc_pkg::BIT_OSC_DRIVE >= $bits(pdc_r)) begin : g_field_check
    $error("field position outside the register word");
  end

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, then the access completes
  // ----------------------------------------------------------------
  // Waitrequest stands for the first cycle of every access only
  assign regIdx         = avsAddress[5:2];
  assign regAligned     = (avsAddress[1:0] == 2'b00);
  assign newRequest     = (avsRead | avsWrite) & ~ack_r;
  assign avsWaitRequest = newRequest;
  assign wrHit          = avsWrite & ack_r & avsByteEnable[0] & regAligned;

  // Per-register write strobes; unmapped indices fall through
  assign pdcWrite       = write_to(regIdx, ewc_pkg::IDX_PORT_DRIVE_CONFIG, wrHit);
  assign sr1Write       = write_to(regIdx, ewc_pkg::IDX_STOP_RECOVERY_ONE, wrHit);
  assign sr2Write       = write_to(regIdx, ewc_pkg::IDX_STOP_RECOVERY_TWO, wrHit);
  assign wdmWrite       = write_to(regIdx, ewc_pkg::IDX_WATCHDOG_MODE, wrHit);

  // Acknowledge and read data: next values
  always_comb begin
    ack_nxt    = newRequest;
    rdData_nxt = rdData_r;
    // Only the flag reads back; write-only bits read as zero
    if (avsRead && !ack_r) begin
      rdData_nxt = 32'h0000_0000;
      if (regIdx == ewc_pkg::IDX_STOP_RECOVERY_ONE) begin
        rdData_nxt[ewc_pkg::BIT_RECOVER_FLAG] = sr1_r[ewc_pkg::BIT_RECOVER_FLAG];
      end
    end
  end

  // Acknowledge and read data: registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_r <= 32'h0000_0000;
      ack_r    <= 1'b0;
    end else begin
      rdData_r <= rdData_nxt;
      ack_r    <= ack_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Port drive configuration
  // ----------------------------------------------------------------
  // Whole byte written; the low bits carry no drive function here
  always_comb begin
    pdc_nxt = pdc_r;
    if (pdcWrite) begin
      pdc_nxt = avsWriteData[7:0];
    end
  end

  // Port drive register, set to its reset value only by full reset
  always_ff @(posedge clk) begin
    if (srst) begin
      pdc_r <= ewc_pkg::RST_PORT_DRIVE_CONFIG;
    end else begin
      pdc_r <= pdc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Stop-recovery control one
  // ----------------------------------------------------------------
  // Software owns the low seven bits; the flag is never written by software
  always_comb begin
    sr1_nxt = sr1_r;
    if (sr1Write) begin
      sr1_nxt[6:0] = avsWriteData[6:0];
    end
    // Recovery touches only the flag, so a same-cycle write still lands below it
    if (stopRecovery) begin
      sr1_nxt[ewc_pkg::BIT_RECOVER_FLAG] = 1'b1;
    end
  end

  // Recovery control one; full reset is the only way to clear the flag
  always_ff @(posedge clk) begin
    if (srst) begin
      sr1_r <= ewc_pkg::RST_STOP_RECOVERY_ONE;
    end else begin
      sr1_r <= sr1_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Stop-recovery control two and watchdog mode
  // ----------------------------------------------------------------
  // Neither register looks at the recovery pulse, so both survive it
  always_comb begin
    sr2_nxt = sr2_r;
    wdm_nxt = wdm_r;
    if (sr2Write) begin
      sr2_nxt = avsWriteData[7:0];
    end
    if (wdmWrite) begin
      wdm_nxt = avsWriteData[7:0] & ewc_pkg::WDM_WRITE_MASK;
    end
  end

  // Retained registers, set to their reset values only by full reset
  always_ff @(posedge clk) begin
    if (srst) begin
      sr2_r <= ewc_pkg::RST_STOP_RECOVERY_TWO;
      wdm_r <= ewc_pkg::RST_WATCHDOG_MODE;
    end else begin
      sr2_r <= sr2_nxt;
      wdm_r <= wdm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs from registers
  // ----------------------------------------------------------------
  assign avsReadData                = rdData_r;
  assign driveSel.oscStandard       = pdc_r[ewc_pkg::BIT_OSC_DRIVE];
  assign driveSel.port3Standard     = pdc_r[ewc_pkg::BIT_PORT3_DRIVE];
  assign driveSel.port2Standard     = pdc_r[ewc_pkg::BIT_PORT2_DRIVE];
  assign wdtCfg.clkFromXtal         = wdm_r[ewc_pkg::BIT_WDT_XTAL];
  assign wdtCfg.runInStop           = wdm_r[ewc_pkg::BIT_WDT_STOP];
  assign wdtCfg.runInHalt           = wdm_r[ewc_pkg::BIT_WDT_HALT];
  assign wdtCfg.tap                 = wdm_r[ewc_pkg::BIT_TAP_HI:0];
  assign wdtCfg.timeoutClks         = tap_clks(wdm_r[ewc_pkg::BIT_TAP_HI:0]);
  assign recoveryCtrl               = sr1_r[6:0];
  assign recoverySrc2               = sr2_r[1:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Recovery pulse outside reset
  sequence s_recover;
    stopRecovery && !srst;
  endsequence

  // Recovery pulse with no software write to register one alongside it
  sequence s_recover_only;
    stopRecovery && !srst && !sr1Write;
  endsequence

  // Completing write to the port drive register
  sequence s_pdc_write;
    pdcWrite && !srst;
  endsequence

  // Completing write to the watchdog mode register
  sequence s_wdm_write;
    wdmWrite && !srst;
  endsequence

  // Completing write to recovery register two
  sequence s_sr2_write;
    sr2Write && !srst;
  endsequence

  // First cycle of a read of recovery register one, when the answer is latched
  sequence s_flag_read;
    avsRead && !ack_r && !srst && regIdx == ewc_pkg::IDX_STOP_RECOVERY_ONE;
  endsequence

  // Stop-mode recovery and retention
  a_recover_keeps_low: assert property (@(posedge clk) disable iff (srst)
    s_recover_only |=> sr1_r[6:0] == $past(sr1_r[6:0]) && sr1_r[ewc_pkg::BIT_RECOVER_FLAG])
    else $error("recovery altered low bits of recovery register one");
  a_recover_keeps_wdm: assert property (@(posedge clk) disable iff (srst)
    (stopRecovery && !wdmWrite && !sr2Write) |=> $stable(wdm_r) && $stable(sr2_r))
    else $error("recovery altered retained registers");
  a_sr2_follows_write: assert property (@(posedge clk) disable iff (srst)
    s_sr2_write |=> recoverySrc2 == $past(avsWriteData[1:0]))
    else $error("recovery register two did not follow write");

  // Port drive configuration
  a_pdc_reset_val: assert property (@(posedge clk)
    srst |=> pdc_r == 8'hFE)
    else $error("port drive config reset value wrong");
  a_drive_reset_out: assert property (@(posedge clk)
    srst |=> driveSel == 3'b111)
    else $error("drive selection after reset not standard");
  a_pdc_needs_enable: assert property (@(posedge clk) disable iff (srst)
    (avsWrite && ack_r && !avsByteEnable[0]) |=> $stable(pdc_r))
    else $error("port drive changed on a disabled byte lane");
  a_osc_drive_map: assert property (@(posedge clk) disable iff (srst)
    s_pdc_write |=> driveSel.oscStandard == $past(avsWriteData[ewc_pkg::BIT_OSC_DRIVE]))
    else $error("oscillator drive did not follow write");
  a_port3_drive_map: assert property (@(posedge clk) disable iff (srst)
    s_pdc_write |=> driveSel.port3Standard == $past(avsWriteData[ewc_pkg::BIT_PORT3_DRIVE]))
    else $error("port 3 drive did not follow write");
  a_port2_drive_map: assert property (@(posedge clk) disable iff (srst)
    s_pdc_write |=> driveSel.port2Standard == $past(avsWriteData[ewc_pkg::BIT_PORT2_DRIVE]))
    else $error("port 2 drive did not follow write");

  // Watchdog mode
  a_wdm_top_zero: assert property (@(posedge clk) disable iff (srst)
    s_wdm_write |=> wdm_r[7:5] == 3'b000)
    else $error("reserved watchdog mode bits not zero");
  a_wdm_reset_val: assert property (@(posedge clk)
    srst |=> !wdtCfg.clkFromXtal && wdtCfg.runInStop && wdtCfg.runInHalt && wdtCfg.tap == 2'b01)
    else $error("watchdog mode reset value wrong");
  a_xtal_follows_write: assert property (@(posedge clk) disable iff (srst)
    s_wdm_write |=> wdtCfg.clkFromXtal == $past(avsWriteData[ewc_pkg::BIT_WDT_XTAL]))
    else $error("watchdog clock source did not follow write");
  a_stop_follows_write: assert property (@(posedge clk) disable iff (srst)
    s_wdm_write |=> wdtCfg.runInStop == $past(avsWriteData[ewc_pkg::BIT_WDT_STOP]))
    else $error("watchdog stop enable did not follow write");
  a_halt_follows_write: assert property (@(posedge clk) disable iff (srst)
    s_wdm_write |=> wdtCfg.runInHalt == $past(avsWriteData[ewc_pkg::BIT_WDT_HALT]))
    else $error("watchdog halt enable did not follow write");
  a_tap_follows_write: assert property (@(posedge clk) disable iff (srst)
    s_wdm_write |=> wdtCfg.tap == $past(avsWriteData[ewc_pkg::BIT_TAP_HI:0]))
    else $error("watchdog tap did not follow write");
  a_tap_timeout: assert property (@(posedge clk) disable iff (srst)
    wdtCfg.tap == 2'b11 |-> wdtCfg.timeoutClks == 12'h800)
    else $error("tap 3 timeout wrong");

  // Recovery flag and read-back
  a_flag_on_recover: assert property (@(posedge clk) disable iff (srst)
    s_recover |=> sr1_r[ewc_pkg::BIT_RECOVER_FLAG])
    else $error("recovery flag not set by recovery");
  a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
    sr1_r[7] |=> sr1_r[7])
    else $error("recovery flag cleared without power-on");
  a_flag_reads_back: assert property (@(posedge clk) disable iff (srst)
    s_flag_read |=> avsReadData[ewc_pkg::BIT_RECOVER_FLAG] == $past(sr1_r[ewc_pkg::BIT_RECOVER_FLAG]))
    else $error("recovery flag read back wrong");
  a_wo_reads_zero: assert property (@(posedge clk) disable iff (srst)
    (avsRead && !ack_r && regIdx != ewc_pkg::IDX_STOP_RECOVERY_ONE) |=> avsReadData == 32'h0000_0000)
    else $error("write-only register read back nonzero");

endmodule // ewc_config_regs

//--- rtl/ewc_pkg.sv
/*
  Package for the expanded-bank configuration registers: offsets, field positions,
  reset values and shared types.
  Assumes an 8-bit register word on a 32-bit Avalon-MM slave, index times four.
*/
package ewc_pkg;

  // ----------------------------------------------------------------
  // Register indices and address width
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_PORT_DRIVE_CONFIG = 4'h0;
  localparam logic [3:0] IDX_STOP_RECOVERY_ONE = 4'hB;
  localparam logic [3:0] IDX_STOP_RECOVERY_TWO = 4'hD;
  localparam logic [3:0] IDX_WATCHDOG_MODE     = 4'hF;
  localparam int         ADDR_W                = 6;

  // ----------------------------------------------------------------
  // Reset values and the watchdog mode write mask
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT_DRIVE_CONFIG = 8'hFE;
  localparam logic [7:0] RST_STOP_RECOVERY_ONE = 8'h20;
  localparam logic [7:0] RST_STOP_RECOVERY_TWO = 8'h00;
  localparam logic [7:0] RST_WATCHDOG_MODE     = 8'h0D;
  localparam logic [7:0] WDM_WRITE_MASK        = 8'h1F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_OSC_DRIVE    = 7;
  localparam int BIT_PORT3_DRIVE  = 6;
  localparam int BIT_PORT2_DRIVE  = 5;
  localparam int BIT_RECOVER_FLAG = 7;
  localparam int BIT_WDT_XTAL     = 4;
  localparam int BIT_WDT_STOP     = 3;
  localparam int BIT_WDT_HALT     = 2;
  localparam int BIT_TAP_HI       = 1;

  // ----------------------------------------------------------------
  // Watchdog timeout in system clocks per tap code
  // ----------------------------------------------------------------
  localparam logic [11:0] TAP0_CLKS = 12'h080;
  localparam logic [11:0] TAP1_CLKS = 12'h100;
  localparam logic [11:0] TAP2_CLKS = 12'h200;
  localparam logic [11:0] TAP3_CLKS = 12'h800;

  // Drive selection presented to the pad ring
  typedef struct packed {
    logic oscStandard;
    logic port3Standard;
    logic port2Standard;
  } ewc_drive_t;

  // Watchdog configuration presented to the watchdog unit
  typedef struct packed {
    logic        clkFromXtal;
    logic        runInStop;
    logic        runInHalt;
    logic [1:0]  tap;
    logic [11:0] timeoutClks;
  } ewc_wdt_cfg_t;

endpackage

//--- test/test_ewc_config_regs.sv
/*
  Self-checking bench for the expanded-bank configuration registers: reset values,
  drive and watchdog fields, stop-recovery retention and the recovery flag.
  Assumes the Avalon slave answers after its wait state; the bench drives every port itself.
*/
`timescale 1ns/100ps
module test_ewc_config_regs;
  logic                  clk, srst, stopRecovery, avsRead, avsWrite, avsWaitRequest;
  logic [5:0]            avsAddress;
  logic [31:0]           avsWriteData, avsReadData, rd;
  logic [3:0]            avsByteEnable;
  logic [6:0]            recoveryCtrl;
  logic [1:0]            recoverySrc2;
  logic [11:0]           tbl [4] = '{12'h080, 12'h100, 12'h200, 12'h800};
  ewc_pkg::ewc_drive_t   driveSel;
  ewc_pkg::ewc_wdt_cfg_t wdtCfg;
  int                    mismatches = 0, checks_done = 0;

  ewc_config_regs u_dut (.clk, .srst, .stopRecovery, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable, .avsReadData, .avsWaitRequest, .driveSel, .wdtCfg, .recoveryCtrl, .recoverySrc2);

  // ----------------------------------------------------------------
  // Clock, checks and bus access
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge, then releases it
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    avsAddress   <= a;
    avsWriteData <= {24'h00_0000, d};
    avsWrite     <= wr;
    avsRead      <= ~wr;
    do begin
      @(posedge clk);
    end while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("driveSel", 32'(3'b111), 32'(driveSel));
    chk("wdtCfg", 32'h0000_D100, 32'(wdtCfg));
    chk("recoveryCtrl", 32'h0000_0020, 32'(recoveryCtrl));
    bus(1'b0, 6'h2C, 8'h00);
    chk("flag", 32'h0000_0000, rd);
    $display("test reset done");
  endtask

  task automatic t_drive;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 6'h00, 8'h80 >> i);
      chk("driveSel", 32'(3'b100 >> i), 32'(driveSel));
    end
    avsByteEnable <= 4'h0;
    bus(1'b1, 6'h00, 8'hFF);
    avsByteEnable <= 4'hF;
    chk("driveSel", 32'(3'b001), 32'(driveSel));
    bus(1'b0, 6'h00, 8'h00);
    chk("readPort", 32'h0000_0000, rd);
    bus(1'b0, 6'h04, 8'h00);
    chk("readUnmapped", 32'h0000_0000, rd);
    $display("test drive done");
  endtask

  task automatic t_wdt;
    logic [1:0] t;
    for (int i = 0; i < 4; i++) begin
      t = 2'(i);
      bus(1'b1, 6'h3C, {3'b000, t[0], t[1], ~t[0], t});
      chk("wdtCfg", 32'({t[0], t[1], ~t[0], t, tbl[i]}), 32'(wdtCfg));
    end
    $display("test watchdog done");
  endtask

  task automatic t_recover;
    bus(1'b1, 6'h2C, 8'h55);
    bus(1'b1, 6'h34, 8'h02);
    bus(1'b1, 6'h3C, 8'h0E);
    stopRecovery <= 1'b1;
    @(posedge clk);
    stopRecovery <= 1'b0;
    @(posedge clk);
    chk("recoveryCtrl", 32'h0000_0055, 32'(recoveryCtrl));
    chk("recoverySrc2", 32'h0000_0002, 32'(recoverySrc2));
    chk("wdtCfg", 32'h0000_E200, 32'(wdtCfg));
    bus(1'b1, 6'h2C, 8'h00);
    bus(1'b0, 6'h2C, 8'h00);
    chk("flag", 32'h0000_0080, rd);
    chk("recoveryCtrl", 32'h0000_0000, 32'(recoveryCtrl));
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 6'h2C, 8'h00);
    chk("flag", 32'h0000_0000, rd);
    chk("recoverySrc2", 32'h0000_0000, 32'(recoverySrc2));
    chk("wdtCfg", 32'h0000_D100, 32'(wdtCfg));
    $display("test recovery done");
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short well past the sixty or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  initial begin
    srst = 1'b1;
    stopRecovery = 1'b0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = 6'h00;
    avsWriteData = 32'h0000_0000;
    avsByteEnable = 4'hF;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_drive();
    t_wdt();
    t_recover();
    end_sim();
  end
endmodule // test_ewc_config_regs
